// ==== src/qmode_pkg.sv ====
/*
  Shared constants for the quad mode entry and exit link: instruction bytes,
  mode bit patterns, discovery data, phase lengths and the controller's
  register map.
  Assumes both ends import it whole and nothing else defines these names.
*/
package qmode_pkg;

  // **********************************************************************
  // Instruction bytes
  // **********************************************************************
  localparam logic [7:0] OP_RD_SR1 = 8'h05;
  localparam logic [7:0] OP_RD_SR2 = 8'h35;
  localparam logic [7:0] OP_WR_SR = 8'h01;
  localparam logic [7:0] OP_QPI_ON = 8'h38;
  localparam logic [7:0] OP_QPI_OFF = 8'hf5;
  localparam logic [7:0] OP_QREAD = 8'heb;
  localparam logic [7:0] OP_SFDP = 8'h5a;

  // **********************************************************************
  // Status bits, mode bits and discovery data
  // **********************************************************************
  localparam int QE_POS = 1;
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] SR2_RST = 8'h00;
  localparam logic [3:0] MODE_ENTER_HI = 4'ha;
  localparam logic [7:0] MODE_EXIT = 8'h00;
  localparam logic [3:0] RESET_NIB = 4'hf;
  localparam logic [3:0] RESET_CLKS = 4'h8;
  // Dword 15: hold/wp disable 0b, quad enable placement 101b, 0-4-4 and 4-4-4 codes
  localparam logic [31:0] SFDP_DW15 = 32'hff5df622;
  localparam logic [7:0] SFDP_DW15_ADDR = 8'h38;
  localparam logic [7:0] UNMAPPED_BYTE = 8'hff;

  // **********************************************************************
  // Phase lengths in bits on the lines, the discovery dummy in clocks
  // **********************************************************************
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] WSR_BITS = 6'h10;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] QREAD_DUMMY_BITS = 6'h10;
  localparam logic [5:0] SFDP_DUMMY_CLKS = 6'h08;

  // **********************************************************************
  // Controller register map and fields
  // **********************************************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam int CMD_OP_LSB = 0;
  localparam int WD_SR1_LSB = 0;
  localparam int WD_SR2_LSB = 8;
  localparam int WD_MODE_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_QPI = 1;
  localparam int ST_CONT = 2;
  localparam int ST_QE = 3;
  localparam int ST_ERR = 4;
  localparam int ST_RX_LSB = 8;

  typedef enum logic [2:0] {
    HOP_RD_SR1 = 3'h0,
    HOP_RD_SR2 = 3'h1,
    HOP_WR_SR = 3'h2,
    HOP_QPI_ON = 3'h3,
    HOP_QPI_OFF = 3'h4,
    HOP_QREAD = 3'h5,
    HOP_SFDP = 3'h6,
    HOP_MRST = 3'h7
  } host_op_t;

endpackage : qmode_pkg

// ==== src/spi_link_if.sv ====
/*
  The four line serial link between the flash end and the controller end.
  Assumes the controller makes chip select and the serial clock; the data
  lines resolve from both output enables, idle lines read high.
*/
`timescale 1ns/1ns
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_dq;
  logic [3:0] h_oe;
  logic [3:0] d_dq;
  logic [3:0] d_oe;
  logic [3:0] dq;

  // Wire level: controller, then flash, else pulled high
  assign dq = (h_oe & h_dq) | (~h_oe & d_oe & d_dq) | (~h_oe & ~d_oe);

  modport host (output cs_n, output sclk, output h_dq, output h_oe, input dq);
  modport dev (input cs_n, input sclk, input dq, output d_dq, output d_oe);
endinterface : spi_link_if

// ==== src/quad_mode_flash_end.sv ====
/*
  Flash end of the link: status registers with the quad enable bit,
  continuous quad read entry and exit, four wire command mode, and the
  discovery dword that reports these features.
  Assumes mode 0 timing: lines sampled on rising and driven on falling
  serial clock; the clock stands still while chip select is high.
*/
// What this block does
// RULE1: quad enable held in status 2 bit 1
// RULE2: 05h returns status 1, 35h status 2
// RULE3: 01h second byte bit one sets enable
// RULE4: 01h second byte bit zero clears enable
// RULE5: mode bits A5h or Axh enter continuous
// RULE6: host sets quad enable before continuous read
// RULE7: mode bits 00h leave continuous after read
// RULE8: Fh for 8 clocks leaves continuous mode
// RULE9: 38h enters four wire command mode
// RULE10: F5h returns to single line instructions
// RULE11: hold and wp disable reported unsupported
// RULE12: continuous frames start at address phase
`timescale 1ns/1ns
module quad_mode_flash_end
  import qmode_pkg::*;
(
  spi_link_if.dev lnk,          // Link pins, flash side
  input wire logic i_srst,      // Reset, active high, acts without clock
  output logic o_qe,            // Quad enable bit
  output logic o_qpi,           // Four wire command mode active
  output logic o_cont           // Continuous quad read active
);

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD = 3'b001,
    PH_ADDR = 3'b011,
    PH_MODE = 3'b010,
    PH_DUMMY = 3'b110,
    PH_XMIT = 3'b111,
    PH_WDATA = 3'b101,
    PH_SKIP = 3'b100
  } phase_t;

  // ********************************************************************
  // State
  // ********************************************************************
  phase_t phase_q, phase_d;
  logic [5:0] cnt_q, cnt_d;
  logic [23:0] sh_q;
  logic [7:0] op_q, op_d;
  logic quad_q, quad_d;
  logic cfr_q, cfr_d;
  logic allf_q, allf_d;
  logic [3:0] fclk_q, fclk_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] byte_q, byte_d;
  logic [7:0] sr1_q, sr1_d;
  logic [7:0] sr2_q, sr2_d;
  logic qpi_q, qpi_d;
  logic cont_q, cont_d;
  logic [3:0] dq_q;
  logic [3:0] oe_q;

  // Frame state drops whenever chip select is high
  wire frame_rst = lnk.cs_n | i_srst;

  // ********************************************************************
  // Decode of the current edge
  // ********************************************************************
  // First edge of a frame picks command or, in continuous mode, address
  wire first = (phase_q == PH_IDLE);
  wire phase_t ph = first ? (cont_q ? PH_ADDR : PH_CMD) : phase_q; // see RULE12
  wire wide = qpi_q | quad_q | (first & cont_q);
  wire [5:0] step = wide ? 6'h04 : 6'h01;
  wire [5:0] cnt_nx = cnt_q + step;
  wire [23:0] sh_nx = wide ? {sh_q[19:0], lnk.dq} : {sh_q[22:0], lnk.dq[0]};
  wire [7:0] opc = sh_nx[7:0];
  wire [5:0] dummy_len = quad_q ? QREAD_DUMMY_BITS : 6'(SFDP_DUMMY_CLKS * step);
  wire [5:0] len = (ph == PH_CMD) ? CMD_BITS :
                   (ph == PH_ADDR) ? ADDR_BITS :
                   (ph == PH_MODE) ? MODE_BITS :
                   (ph == PH_DUMMY) ? dummy_len :
                   (ph == PH_WDATA) ? WSR_BITS : BYTE_BITS;
  wire done = (cnt_nx == len);
  wire is_cfr = first ? cont_q : cfr_q;
  wire allf_now = (first | allf_q) & (lnk.dq == RESET_NIB);
  wire reset_seen = is_cfr & allf_now & (fclk_q == RESET_CLKS - 4'h1);
  wire is_read = (op_q == OP_QREAD) | (op_q == OP_SFDP);

  // Read data: discovery dword at its window, address echo for the array
  wire [7:0] rd_addr = (ph == PH_XMIT) ? addr_q + 8'h01 : addr_q;
  wire sfdp_hit = (rd_addr[7:2] == SFDP_DW15_ADDR[7:2]);
  wire [7:0] sfdp_byte = sfdp_hit ? SFDP_DW15[{rd_addr[1:0], 3'h0} +: 8] : UNMAPPED_BYTE; // see RULE1
  wire [7:0] rd_byte = (op_q == OP_SFDP) ? sfdp_byte : rd_addr; // see RULE11

  // ********************************************************************
  // Next state of the frame and of the persistent modes
  // ********************************************************************
  always_comb
  begin
    phase_d = ph;
    cnt_d = done ? 6'h00 : cnt_nx;
    op_d = first ? (cont_q ? OP_QREAD : 8'h00) : op_q;
    quad_d = first ? cont_q : quad_q;
    cfr_d = is_cfr;
    allf_d = allf_now;
    fclk_d = (fclk_q == RESET_CLKS) ? fclk_q : fclk_q + 4'h1;
    addr_d = addr_q;
    byte_d = byte_q;
    sr1_d = sr1_q;
    sr2_d = sr2_q;
    qpi_d = qpi_q;
    cont_d = cont_q;
    if (reset_seen)
    begin
      // Fh on all four lines for the whole opening leaves the mode
      cont_d = 1'b0; // see RULE8
      phase_d = PH_SKIP;
    end
    else
    begin
      unique case (ph)
        PH_CMD:
        begin
          if (done)
          begin
            op_d = opc;
            phase_d = PH_SKIP;
            if (opc == OP_RD_SR1)
            begin
              phase_d = PH_XMIT; // see RULE2
              byte_d = sr1_q;
            end
            else if (opc == OP_RD_SR2)
            begin
              phase_d = PH_XMIT; // see RULE2
              byte_d = sr2_q;
            end
            else if (opc == OP_WR_SR)
              phase_d = PH_WDATA;
            else if (opc == OP_QPI_ON)
              qpi_d = 1'b1; // see RULE9
            else if (opc == OP_QPI_OFF && qpi_q)
              qpi_d = 1'b0; // see RULE10
            else if (opc == OP_QREAD && sr2_q[QE_POS])
            begin
              phase_d = PH_ADDR;
              quad_d = 1'b1;
            end
            else if (opc == OP_SFDP)
              phase_d = PH_ADDR;
          end
        end
        PH_ADDR:
        begin
          if (done)
          begin
            addr_d = sh_nx[7:0];
            phase_d = (op_q == OP_QREAD || is_cfr) ? PH_MODE : PH_DUMMY;
          end
        end
        PH_MODE:
        begin
          if (done)
          begin
            // Axh (A5h among them) keeps or enters, 00h and others leave after this read
            cont_d = (sh_nx[7:4] == MODE_ENTER_HI); // see RULE5
            if (sh_nx[7:0] == MODE_EXIT)
              cont_d = 1'b0; // see RULE7
            phase_d = PH_DUMMY;
          end
        end
        PH_DUMMY:
        begin
          if (done)
          begin
            phase_d = PH_XMIT;
            byte_d = rd_byte;
          end
        end
        PH_XMIT:
        begin
          // Status bytes repeat, reads step to the next address
          if (done && is_read)
          begin
            addr_d = rd_addr;
            byte_d = rd_byte;
          end
        end
        PH_WDATA:
        begin
          if (done)
          begin
            sr1_d = sh_nx[15:8];
            sr2_d = sh_nx[7:0]; // see RULE3 RULE4
            phase_d = PH_SKIP;
          end
        end
        PH_SKIP:
          cnt_d = 6'h00;
        default:
          phase_d = PH_SKIP;
      endcase
    end
  end

  // ********************************************************************
  // Frame registers, cleared by chip select high
  // ********************************************************************
  always_ff @(posedge lnk.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      phase_q <= PH_IDLE;
      cnt_q <= 6'h00;
      sh_q <= 24'h000000;
      op_q <= 8'h00;
      quad_q <= 1'b0;
      cfr_q <= 1'b0;
      allf_q <= 1'b0;
      fclk_q <= 4'h0;
      addr_q <= 8'h00;
      byte_q <= 8'h00;
    end
    else
    begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      sh_q <= sh_nx;
      op_q <= op_d;
      quad_q <= quad_d;
      cfr_q <= cfr_d;
      allf_q <= allf_d;
      fclk_q <= fclk_d;
      addr_q <= addr_d;
      byte_q <= byte_d;
    end
  end

  // ********************************************************************
  // Persistent status and mode registers
  // ********************************************************************
  always_ff @(posedge lnk.sclk or posedge i_srst)
  begin
    if (i_srst)
    begin
      sr1_q <= SR1_RST;
      sr2_q <= SR2_RST;
      qpi_q <= 1'b0;
      cont_q <= 1'b0;
    end
    else
    begin
      sr1_q <= sr1_d;
      sr2_q <= sr2_d;
      qpi_q <= qpi_d;
      cont_q <= cont_d;
    end
  end

  // ********************************************************************
  // Output lines, changed on the falling edge
  // ********************************************************************
  wire [2:0] bit_idx = cnt_q[2:0];
  wire [3:0] nib = bit_idx[2] ? byte_q[3:0] : byte_q[7:4];
  wire so_bit = byte_q[3'h7 - bit_idx];
  wire xmit = (phase_q == PH_XMIT);
  wire [3:0] dq_nx = ~xmit ? 4'h0 : (wide ? nib : {2'h0, so_bit, 1'b0});
  wire [3:0] oe_nx = ~xmit ? 4'h0 : (wide ? 4'hf : 4'h2);

  always_ff @(negedge lnk.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      dq_q <= 4'h0;
      oe_q <= 4'h0;
    end
    else
    begin
      dq_q <= dq_nx;
      oe_q <= oe_nx;
    end
  end

  assign lnk.d_dq = dq_q;
  assign lnk.d_oe = oe_q;
  assign o_qe = sr2_q[QE_POS]; // see RULE1
  assign o_qpi = qpi_q;
  assign o_cont = cont_q;

endmodule : quad_mode_flash_end

// ==== src/quad_mode_host_end.sv ====
/*
  Controller end of the link: takes orders over a plain register port and
  runs status, mode entry and exit, and read frames on the four lines.
  Assumes one flash on the link; the serial clock is divided from i_clk.
*/
`timescale 1ns/1ns
module quad_mode_host_end
  import qmode_pkg::*;
#(
  parameter int HALF_DIV = 4  // i_clk cycles per serial clock half, at least 3
)
(
  input wire logic i_clk,           // System clock
  input wire logic i_srst,          // Synchronous reset, active high
  input wire logic [3:0] i_addr,    // Register byte address
  input wire logic [31:0] i_wdata,  // Register write data
  input wire logic i_wr,            // Write strobe
  input wire logic i_rd,            // Read strobe
  output logic [31:0] o_rdata,      // Read data, the cycle after i_rd
  spi_link_if.host lnk              // Link pins, controller side
);

  typedef enum logic [2:0] {
    HP_IDLE = 3'b000,
    HP_CMD = 3'b001,
    HP_ADDR = 3'b011,
    HP_MODE = 3'b010,
    HP_DUMMY = 3'b110,
    HP_DIN = 3'b111,
    HP_END = 3'b101,
    HP_DOUT = 3'b100
  } hphase_t;

  // ********************************************************************
  // State
  // ********************************************************************
  hphase_t ph_q, ph_d;
  host_op_t op_q, op_d;
  logic [7:0] div_q, div_d;
  logic [5:0] cnt_q, cnt_d;
  logic [39:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] sav_q, sav_d;
  logic [23:0] addr_q, addr_d;
  logic [23:0] wdata_q, wdata_d;
  logic qpi_q, qpi_d, cont_q, cont_d, qe_q, qe_d, err_q, err_d;
  logic sclk_q, sclk_d, cs_n_q, cs_n_d;
  logic [3:0] dq_q, dq_d, oe_q, oe_d;
  logic [3:0] s1_q, s2_q;
  logic [31:0] rdata_q, rdata_d;

  // ********************************************************************
  // Order decode and frame set-up
  // ********************************************************************
  wire host_op_t nop = host_op_t'(i_wdata[CMD_OP_LSB +: 3]);
  wire wr_cmd = i_wr && (i_addr == REG_CMD);
  wire start_ok = wr_cmd && (ph_q == HP_IDLE) && !(nop == HOP_QREAD && !qe_q); // see RULE6
  wire [7:0] nmode = wdata_q[WD_MODE_LSB +: 8];
  wire [7:0] ncmd = (nop == HOP_RD_SR1) ? OP_RD_SR1 :
                    (nop == HOP_RD_SR2) ? OP_RD_SR2 :
                    (nop == HOP_WR_SR) ? OP_WR_SR :
                    (nop == HOP_QPI_ON) ? OP_QPI_ON : // see RULE9
                    (nop == HOP_QPI_OFF) ? OP_QPI_OFF : // see RULE10
                    (nop == HOP_QREAD) ? OP_QREAD : OP_SFDP;
  // Status 1 byte goes out first, the status 2 byte with the enable bit second
  wire [15:0] wsr_bytes = {wdata_q[WD_SR1_LSB +: 8], wdata_q[WD_SR2_LSB +: 8]};
  // Continuous frames open on the address, a mode reset is Fh throughout
  wire [39:0] tx_load = (nop == HOP_MRST) ? {40{1'b1}} : // see RULE8
                        (nop == HOP_WR_SR) ? {ncmd, wsr_bytes, 16'h0000} : // see RULE3 RULE4
                        (nop == HOP_QREAD && cont_q) ? {addr_q, nmode, 8'h00} : // see RULE12
                        (nop == HOP_QREAD) ? {ncmd, addr_q, nmode} :
                        (nop == HOP_SFDP) ? {ncmd, addr_q, 8'h00} : {ncmd, 32'h00000000};
  wire hphase_t first_ph = (nop == HOP_MRST) ? HP_DOUT :
                           (nop == HOP_QREAD && cont_q) ? HP_ADDR : HP_CMD;
  wire [7:0] nsav = (nop == HOP_WR_SR) ? wdata_q[WD_SR2_LSB +: 8] : nmode;

  // ********************************************************************
  // Phase sequencing
  // ********************************************************************
  wire wide = qpi_q | (op_q == HOP_MRST) | (op_q == HOP_QREAD && ph_q != HP_CMD);
  wire [5:0] step = wide ? 6'h04 : 6'h01;
  wire [5:0] cnt_nx = cnt_q + step;
  wire [5:0] len = (ph_q == HP_CMD) ? CMD_BITS :
                   (ph_q == HP_ADDR) ? ADDR_BITS :
                   (ph_q == HP_MODE) ? MODE_BITS :
                   (ph_q == HP_DUMMY) ? ((op_q == HOP_QREAD) ? QREAD_DUMMY_BITS :
                                         6'(SFDP_DUMMY_CLKS * step)) :
                   (ph_q == HP_DOUT) ? ((op_q == HOP_MRST) ? 6'(RESET_CLKS * 4) : WSR_BITS) :
                   BYTE_BITS;
  wire done = (cnt_nx == len);
  wire hphase_t ph_nx = (ph_q == HP_CMD) ?
                          ((op_q == HOP_RD_SR1 || op_q == HOP_RD_SR2) ? HP_DIN :
                           (op_q == HOP_WR_SR) ? HP_DOUT :
                           (op_q == HOP_QREAD || op_q == HOP_SFDP) ? HP_ADDR : HP_END) :
                        (ph_q == HP_ADDR) ? ((op_q == HOP_QREAD) ? HP_MODE : HP_DUMMY) :
                        (ph_q == HP_MODE) ? HP_DUMMY :
                        (ph_q == HP_DUMMY) ? HP_DIN : HP_END;
  wire div_last = (div_q == 8'(HALF_DIV - 1));
  wire rise = (ph_q != HP_IDLE) && (ph_q != HP_END) && div_last && !sclk_q;
  wire fall = (ph_q != HP_IDLE) && div_last && sclk_q;
  wire drive_ph = (ph_q == HP_CMD) || (ph_q == HP_ADDR) || (ph_q == HP_MODE) ||
                  (ph_q == HP_DOUT);
  wire [3:0] dq_val = wide ? tx_q[39:36] : {3'h0, tx_q[39]};
  wire [3:0] oe_val = wide ? 4'hf : 4'h1;
  wire [7:0] rx_nx = wide ? {rx_q[3:0], s2_q} : {rx_q[6:0], s2_q[1]};

  // ********************************************************************
  // Frame engine
  // ********************************************************************
  always_comb
  begin
    ph_d = ph_q;
    op_d = op_q;
    div_d = (ph_q == HP_IDLE || div_last) ? 8'h00 : div_q + 8'h01;
    cnt_d = cnt_q;
    tx_d = tx_q;
    rx_d = rx_q;
    sav_d = sav_q;
    qpi_d = qpi_q;
    cont_d = cont_q;
    qe_d = qe_q;
    err_d = err_q;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    // Line values change, and drivers turn on, only while the serial clock is low
    dq_d = sclk_q ? dq_q : dq_val;
    oe_d = !drive_ph ? 4'h0 : (sclk_q ? oe_q : oe_val);
    if (ph_q == HP_IDLE)
    begin
      if (start_ok)
      begin
        ph_d = first_ph;
        op_d = nop;
        tx_d = tx_load;
        sav_d = nsav;
        cnt_d = 6'h00;
        cs_n_d = 1'b0;
        err_d = 1'b0;
      end
      else if (wr_cmd)
        err_d = 1'b1;
    end
    else
    begin
      if (wr_cmd)
        err_d = 1'b1;
      if (rise)
      begin
        sclk_d = 1'b1;
        cnt_d = done ? 6'h00 : cnt_nx;
        tx_d = wide ? {tx_q[35:0], 4'h0} : {tx_q[38:0], 1'b0};
        if (ph_q == HP_DIN)
          rx_d = rx_nx;
        if (done)
          ph_d = ph_nx;
      end
      if (fall)
      begin
        sclk_d = 1'b0;
        if (ph_q == HP_END)
        begin
          ph_d = HP_IDLE;
          cs_n_d = 1'b1;
          unique case (op_q)
            HOP_QPI_ON: qpi_d = 1'b1; // see RULE9
            HOP_QPI_OFF: qpi_d = 1'b0; // see RULE10
            HOP_WR_SR: qe_d = sav_q[QE_POS]; // see RULE3 RULE4
            HOP_RD_SR2: qe_d = rx_q[QE_POS];
            HOP_QREAD: cont_d = (sav_q[7:4] == MODE_ENTER_HI) && (sav_q != MODE_EXIT); // see RULE5 RULE7
            HOP_MRST: cont_d = 1'b0; // see RULE8
            HOP_RD_SR1, HOP_SFDP: ;
          endcase
        end
      end
    end
  end

  // ********************************************************************
  // Register port
  // ********************************************************************
  wire [31:0] stat = {16'h0000, rx_q, 3'h0, err_q, qe_q, cont_q, qpi_q, (ph_q != HP_IDLE)};
  assign addr_d = (i_wr && i_addr == REG_ADDR) ? i_wdata[23:0] : addr_q;
  assign wdata_d = (i_wr && i_addr == REG_WDATA) ? i_wdata[23:0] : wdata_q;
  assign rdata_d = !i_rd ? 32'h00000000 :
                   (i_addr == REG_CMD) ? {29'h00000000, op_q} :
                   (i_addr == REG_ADDR) ? {8'h00, addr_q} :
                   (i_addr == REG_WDATA) ? {8'h00, wdata_q} :
                   (i_addr == REG_STAT) ? stat : 32'h00000000;

  // Registers and the data line synchroniser
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ph_q <= HP_IDLE;
      op_q <= HOP_RD_SR1;
      {div_q, cnt_q, tx_q, rx_q, sav_q} <= '0;
      {addr_q, wdata_q, rdata_q} <= '0;
      {qpi_q, cont_q, qe_q, err_q, sclk_q} <= 5'h00;
      cs_n_q <= 1'b1;
      {dq_q, oe_q, s1_q, s2_q} <= 16'h0000;
    end
    else
    begin
      ph_q <= ph_d;
      op_q <= op_d;
      {div_q, cnt_q, tx_q, rx_q, sav_q} <= {div_d, cnt_d, tx_d, rx_d, sav_d};
      {addr_q, wdata_q, rdata_q} <= {addr_d, wdata_d, rdata_d};
      {qpi_q, cont_q, qe_q, err_q, sclk_q} <= {qpi_d, cont_d, qe_d, err_d, sclk_d};
      cs_n_q <= cs_n_d;
      {dq_q, oe_q, s1_q, s2_q} <= {dq_d, oe_d, lnk.dq, s1_q};
    end
  end

  assign o_rdata = rdata_q;
  assign lnk.cs_n = cs_n_q;
  assign lnk.sclk = sclk_q;
  assign lnk.h_dq = dq_q;
  assign lnk.h_oe = oe_q;

endmodule : quad_mode_host_end

// ==== verif/qmode_link_sva.sv ====
/*
  Checker for the four line link between the two ends.
  Assumes the host clock and reset, and a serial clock half of 4 cycles.
*/
`timescale 1ns/1ns
module qmode_link_sva
(
  input wire logic i_clk,       // Host clock
  input wire logic i_srst,      // Host reset
  input wire logic cs_n,        // Chip select
  input wire logic sclk,        // Serial clock
  input wire logic [3:0] h_dq,  // Host values
  input wire logic [3:0] h_oe,  // Host enables
  input wire logic [3:0] d_dq,  // Flash values
  input wire logic [3:0] d_oe   // Flash enables
);
  // ****************************************
  // Link timing and ownership
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_idle; cs_n |-> !sclk && d_oe == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("link active while deselected");
  property p_fight; (h_oe & d_oe) == 4'h0; endproperty
  a_fight: assert property (p_fight) else $error("both ends drive");
  property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("serial clock high time");
  property p_lead; $fell(cs_n) |-> !sclk [*3]; endproperty
  a_lead: assert property (p_lead) else $error("clock too soon after select");
  // The host may let go of the lines after the last rising edge, but only turns them on low
  property p_hstab;
    sclk && $past(sclk) |-> $stable(h_dq) && (h_oe == 4'h0 || $stable(h_oe));
  endproperty
  a_hstab: assert property (p_hstab) else $error("host lines move while high");
  property p_dstab; sclk && $past(sclk) |-> $stable(d_dq) && $stable(d_oe); endproperty
  a_dstab: assert property (p_dstab) else $error("flash lines move while high");
  property p_hchg; $changed(h_oe) && h_oe != 4'h0 |-> !sclk; endproperty
  a_hchg: assert property (p_hchg) else $error("host turns lines at high clock");
  property p_gap; $rose(cs_n) |=> cs_n; endproperty
  a_gap: assert property (p_gap) else $error("no idle between frames");
endmodule : qmode_link_sva

// ==== verif/quad_mode_entry_exit_control_tb.sv ====
/*
  Bench joining host end and flash end over the link.
  Assumes the host register map of the package and HALF_DIV of 4.
*/
`timescale 1ns/1ns
module quad_mode_entry_exit_control_tb
  import qmode_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_srst = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic qe;
  logic four_wire_command_mode;
  logic cont;
  logic [31:0] rv;
  int fail_count = 0;
  int total_checks = 0;
  spi_link_if lnk ();
  quad_mode_host_end #(.HALF_DIV(4)) quad_mode_host_end_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .lnk(lnk.host));
  quad_mode_flash_end quad_mode_flash_end_inst (.lnk(lnk.dev), .i_srst(i_srst), .o_qe(qe),
    .o_qpi(four_wire_command_mode), .o_cont(cont));
  qmode_link_sva qmode_link_sva_inst (.i_clk(i_clk), .i_srst(i_srst), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .h_dq(lnk.h_dq), .h_oe(lnk.h_oe), .d_dq(lnk.d_dq), .d_oe(lnk.d_oe));
  // Clock
  always #5 i_clk = ~i_clk;
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  // Runs one frame and waits for busy to drop; rv then holds the status
  task automatic op(input host_op_t o, input logic [23:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wr(REG_ADDR, {8'h00, a});
    wr(REG_WDATA, d);
    wr(REG_CMD, {29'h0, o});
    do
    begin
      rd(REG_STAT);
      n++;
    end
    while (rv[ST_BUSY] !== 1'b0 && n < 3000);
    chk({7'h0, rv[ST_BUSY]}, 8'h00);
  endtask : op
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Watchdog
  initial
  begin
    #300000;
    fail_count++;
    end_sim();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    // A real rising edge, so the flash end's asynchronous reset acts
    i_srst <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(REG_STAT);
    chk(rv[7:0], 8'h00);
    rd(4'h2);
    chk(rv[7:0], 8'h00);
    op(HOP_WR_SR, 24'h0, 32'h0000023c);
    chk({7'h0, qe}, 8'h01);
    op(HOP_RD_SR2, 24'h0, 32'h0);
    chk(rv[ST_RX_LSB +: 8], 8'h02);
    op(HOP_RD_SR1, 24'h0, 32'h0);
    chk(rv[ST_RX_LSB +: 8], 8'h3c);
    for (int i = 0; i < 5; i++)
    begin
      op(HOP_SFDP, 24'h38 + 24'(i), 32'h0);
      chk(rv[ST_RX_LSB +: 8], i < 4 ? SFDP_DW15[8 * i +: 8] : UNMAPPED_BYTE);
    end
    op(HOP_QREAD, 24'h12, 32'h00a50000);
    chk(rv[ST_RX_LSB +: 8], 8'h12);
    chk({7'h0, cont}, 8'h01);
    op(HOP_QREAD, 24'h34, 32'h00a30000);
    chk(rv[ST_RX_LSB +: 8], 8'h34);
    chk({7'h0, cont}, 8'h01);
    op(HOP_MRST, 24'h0, 32'h0);
    chk({6'h0, cont, rv[ST_CONT]}, 8'h00);
    op(HOP_QREAD, 24'h56, 32'h00a50000);
    op(HOP_QREAD, 24'h78, 32'h0);
    chk(rv[ST_RX_LSB +: 8], 8'h78);
    chk({7'h0, cont}, 8'h00);
    op(HOP_QPI_ON, 24'h0, 32'h0);
    chk({6'h0, four_wire_command_mode, rv[ST_QPI]}, 8'h03);
    op(HOP_RD_SR2, 24'h0, 32'h0);
    chk(rv[ST_RX_LSB +: 8], 8'h02);
    op(HOP_QPI_OFF, 24'h0, 32'h0);
    chk({6'h0, four_wire_command_mode, rv[ST_QPI]}, 8'h00);
    op(HOP_WR_SR, 24'h0, 32'h0);
    chk({7'h0, qe}, 8'h00);
    op(HOP_QREAD, 24'h9a, 32'h00a50000);
    chk({6'h0, rv[ST_ERR], cont}, 8'h02);
    end_sim();
  end
endmodule : quad_mode_entry_exit_control_tb
